// [design/arcrf_map.svh]
// Constants for the conversion result capture block.
// Assumes inclusion by the design files only.
`ifndef ARCRF_MAP_SVH
`define ARCRF_MAP_SVH
`define ARCRF_RESULT_WIDTH      12
`define ARCRF_CONV_TIME_NS      500
`define ARCRF_CLK_PERIOD_NS     40
`define ARCRF_CONV_CYCLES       ((`ARCRF_CONV_TIME_NS + `ARCRF_CLK_PERIOD_NS - 1) / `ARCRF_CLK_PERIOD_NS)
`define ARCRF_STROBE_CYCLES     2
`define ARCRF_RESET_CODE        12'h0000
`define ARCRF_ALL_ONES          12'hFFF
`define ARCRF_HALF_LSB_MARGIN   1
`endif

// [design/arcrf_pkg.sv]
// Types shared by the result capture block.
// Assumes the map header is compiled alongside.
package arcrf_pkg;
    typedef enum logic [1:0] {
        ARCRF_IDLE   = 2'b00,
        ARCRF_CONV   = 2'b01,
        ARCRF_STROBE = 2'b11
    } arcrf_state_t;
endpackage

// [design/arcrf_range_judge.sv]
// Range judgement of one sampled input against the selected range.
// Assumes the sample is a signed count of half-LSB steps around the code grid.
`timescale 1ns/1ns
`default_nettype none
`include "arcrf_map.svh"
module arcrf_range_judge #(
    parameter int W = `ARCRF_RESULT_WIDTH
) (
    input  wire logic signed [W+1:0] sample_half_lsb,
    output logic             [W-1:0] code,
    output logic                     exceeded
);
    // Sample is expressed in half-LSB units, so full-scale code centre is 2*(2^W-1).
    localparam logic signed [W+1:0] TOP = (W+2)'(2 * ((1 << W) - 1));
    // The flag rises at the margin or beyond it. The top of the signed input is exactly
    // half an LSB above the top code centre, so overrange stays reachable.
    always_comb begin
        if (sample_half_lsb >= TOP + (W+2)'(`ARCRF_HALF_LSB_MARGIN)) begin
            code     = {W{1'b1}};
            exceeded = 1'b1;
        end else if (sample_half_lsb <= -(W+2)'(`ARCRF_HALF_LSB_MARGIN)) begin
            code     = '0;
            exceeded = 1'b1;
        end else if (sample_half_lsb > TOP) begin
            code     = {W{1'b1}};
            exceeded = 1'b0;
        end else if (sample_half_lsb < 0) begin
            code     = '0;
            exceeded = 1'b0;
        end else begin
            // A count halfway between two centres is a transition point and takes the upper code.
            code     = W'((sample_half_lsb + 1) >>> 1);
            exceeded = 1'b0;
        end
    end
endmodule
`default_nettype wire

// [design/arcrf_core.sv]
// Digital result side of a subranging converter: start pulse, timing, result and range flag.
// Assumes the analog front end supplies the input as a signed half-LSB count.
// The host latch sits outside and clocks itself from the strobe or its inverse.
// How it works
// - Fresh data and range flag are stable before and at the rising edge of the valid strobe.
// - The range flag is low after each conversion whose sampled input is inside the range.
// - The range flag goes high when the input passes either range end by half an LSB.
// - The flag changes only when a conversion completes, so it holds until an in-range one ends.
// - Above range all data bits read high and below range all read low.
// - A conversion starts on the rising edge of the active-high start pulse.
// - Both the true and inverted top bit are presented.
`timescale 1ns/1ns
`default_nettype none
`include "arcrf_map.svh"
module arcrf_core #(
    parameter int W           = `ARCRF_RESULT_WIDTH,
    parameter int CONV_CYCLES = `ARCRF_CONV_CYCLES
) (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               conversion_start_pulse,
    input  wire logic signed [W+1:0] analog_sample,
    output logic             [W-1:0] result_data,
    output logic                    result_msb_n,
    output logic                    range_exceeded_flag,
    output logic                    result_valid_strobe
);
    // The down counter is eight bits wide and the judge works in a 32-bit int, so both
    // parameters are bounded; the early load also needs the counter to pass through one.
    generate
        if (W < 2 || W > 29 || CONV_CYCLES < 2 || CONV_CYCLES > 256) begin : g_bad_params
            $error("arcrf_core: unsupported parameters");
        end
    endgenerate

    // ==========================================================
    // Start edge and timing
    arcrf_pkg::arcrf_state_t state_q;
    logic                    start_prev_q;
    logic [7:0]              cnt_q;
    logic signed [W+1:0]     held_q;
    logic                    start_rise;
    logic [W-1:0]            judged_code;
    logic                    judged_exc;

    // The previous level resets low, the idle level of the pin, so no false edge follows reset.
    // A pulse that is already high when reset ends still counts as one start.
    assign start_rise = conversion_start_pulse & ~start_prev_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= conversion_start_pulse;
        end
    end

    // A start during a conversion is ignored: the timing generator owns the cycle.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= arcrf_pkg::ARCRF_IDLE;
            cnt_q   <= 8'h00;
        end else begin
            case (state_q)
                arcrf_pkg::ARCRF_IDLE: begin
                    if (start_rise) begin
                        state_q <= arcrf_pkg::ARCRF_CONV;
                        cnt_q   <= 8'(CONV_CYCLES - 1);
                    end
                end
                arcrf_pkg::ARCRF_CONV: begin
                    if (cnt_q == 8'h00) begin
                        state_q <= arcrf_pkg::ARCRF_STROBE;
                        cnt_q   <= 8'(`ARCRF_STROBE_CYCLES - 1);
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                arcrf_pkg::ARCRF_STROBE: begin
                    if (cnt_q == 8'h00) begin
                        state_q <= arcrf_pkg::ARCRF_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= arcrf_pkg::ARCRF_IDLE;
                    cnt_q   <= 8'h00;
                end
            endcase
        end
    end

    // ==========================================================
    // Sample hold and judgement
    // The input is taken once, at the start edge, so the judge works on a steady value.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            held_q <= '0;
        end else if (state_q == arcrf_pkg::ARCRF_IDLE && start_rise) begin
            held_q <= analog_sample;
        end
    end

    // The judge is purely combinational; its result is only used at the load cycle.
    arcrf_range_judge #(.W(W)) u_judge (
        .sample_half_lsb (held_q),
        .code            (judged_code),
        .exceeded        (judged_exc)
    );

    // ==========================================================
    // Outputs
    // Data and flag load one cycle before the strobe rises, so they are settled at that edge.
    // A host latch clocked by the strobe would race a word that changed on the same edge;
    // the extra cycle costs nothing because the judged word is ready long before.
    logic load_now;
    logic last_conv;
    assign load_now  = (state_q == arcrf_pkg::ARCRF_CONV) && (cnt_q == 8'h01);
    assign last_conv = (state_q == arcrf_pkg::ARCRF_CONV) && (cnt_q == 8'h00);

    // The flag is written only here, so it keeps its value between conversions.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_data         <= W'(`ARCRF_RESET_CODE);
            result_msb_n        <= 1'b1;
            range_exceeded_flag <= 1'b0;
        end else if (load_now) begin
            result_data         <= judged_code;
            result_msb_n        <= ~judged_code[W-1];
            range_exceeded_flag <= judged_exc;
        end
    end

    // The strobe is high during the stable window; its falling edge precedes any new data.
    // A host clocked by the inverted strobe therefore still captures the finished word.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_valid_strobe <= 1'b0;
        end else begin
            result_valid_strobe <= last_conv ||
                (state_q == arcrf_pkg::ARCRF_STROBE && cnt_q != 8'h00);
        end
    end

    // ==========================================================
    // Checks on conversion timing
    // The strobe length is counted here so that its check is a plain compare; a long
    // repetition would have to be unrolled by the tools.
    logic [7:0] strobe_run_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            strobe_run_q <= 8'h00;
        end else if (result_valid_strobe) begin
            strobe_run_q <= strobe_run_q + 8'h01;
        end else begin
            strobe_run_q <= 8'h00;
        end
    end

    start_to_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == arcrf_pkg::ARCRF_IDLE && start_rise
            |-> ##CONV_CYCLES ##1 $rose(result_valid_strobe))
        else $error("strobe not at conversion end");
    count_down_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == arcrf_pkg::ARCRF_CONV && cnt_q != 8'h00
            |=> state_q == arcrf_pkg::ARCRF_CONV && cnt_q == $past(cnt_q) - 8'h01)
        else $error("conversion counter skipped a step");
    sample_capture_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q == arcrf_pkg::ARCRF_IDLE && start_rise |=> held_q == $past(analog_sample))
        else $error("input not held at start");
    busy_refuse_a: assert property (@(posedge core_clk) disable iff (rst)
        state_q != arcrf_pkg::ARCRF_IDLE |=> $stable(held_q))
        else $error("held input changed during conversion");
    strobe_state_a: assert property (@(posedge core_clk) disable iff (rst)
        result_valid_strobe == (state_q == arcrf_pkg::ARCRF_STROBE))
        else $error("strobe out of step with timing");
    strobe_width_a: assert property (@(posedge core_clk) disable iff (rst)
        $fell(result_valid_strobe) |-> strobe_run_q == 8'(`ARCRF_STROBE_CYCLES))
        else $error("strobe width wrong");

    // ==========================================================
    // Checks on the result word and range flag
    // These watch the registered outputs, so a word that moves on the strobe edge itself,
    // or between conversions, is caught before any host sees it.
    stable_at_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(result_valid_strobe) |-> $stable(result_data) && $stable(range_exceeded_flag))
        else $error("data changed at strobe rise");
    data_hold_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
        result_valid_strobe |=> $stable(result_data) && $stable(range_exceeded_flag))
        else $error("data changed while strobe high");
    code_from_judge_a: assert property (@(posedge core_clk) disable iff (rst)
        load_now |=> result_data == $past(judged_code)
            && range_exceeded_flag == $past(judged_exc))
        else $error("word differs from judged input");
    word_only_load_a: assert property (@(posedge core_clk) disable iff (rst)
        !$past(load_now) |-> $stable(result_data) && $stable(result_msb_n))
        else $error("word changed without conversion end");
    reset_values_a: assert property (@(posedge core_clk) disable iff (rst)
        $past(rst) |-> result_data == W'(`ARCRF_RESET_CODE) && result_msb_n
            && !range_exceeded_flag && !result_valid_strobe)
        else $error("outputs not at reset values");
    flag_low_inrange_a: assert property (@(posedge core_clk) disable iff (rst)
        load_now && !judged_exc |=> !range_exceeded_flag)
        else $error("flag high for in-range input");
    flag_high_over_a: assert property (@(posedge core_clk) disable iff (rst)
        load_now && judged_exc |=> range_exceeded_flag)
        else $error("flag low for out-of-range input");
    flag_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        !$past(load_now) |-> $stable(range_exceeded_flag))
        else $error("flag changed without conversion end");
    rails_code_a: assert property (@(posedge core_clk) disable iff (rst)
        range_exceeded_flag |-> result_data == '0 || result_data == {W{1'b1}})
        else $error("out of range code not at rail");
    msb_pair_a: assert property (@(posedge core_clk) disable iff (rst)
        result_msb_n == ~result_data[W-1])
        else $error("inverted msb mismatch");
endmodule
`default_nettype wire

// [verification/arcrf_host_latch.sv]
// Host side model that captures each conversion result off the core.
// Assumes it shares the core clock and watches the result outputs directly.
`timescale 1ns/1ns
`default_nettype none
module arcrf_host_latch (
    input  wire logic        core_clk,
    input  wire logic [11:0] result_data,
    input  wire logic        range_exceeded_flag,
    input  wire logic        result_valid_strobe,
    output logic      [11:0] cap_data,
    output logic             cap_flag,
    output logic      [1:0]  cap_range,
    output logic      [11:0] fall_data
);
    logic strobe_q = 1'b0;
    // ====================
    // Capture and decode
    // Sampling one clock into the strobe sees the settled new word, as a real latch would.
    always_ff @(posedge core_clk) begin
        strobe_q <= result_valid_strobe;
        if (result_valid_strobe && !strobe_q) begin
            cap_data  <= result_data;
            cap_flag  <= range_exceeded_flag;
            cap_range <= {range_exceeded_flag, range_exceeded_flag & result_data[11]};
        end
        // A second latch clocked from the inverted strobe keeps the word as the strobe falls.
        if (!result_valid_strobe && strobe_q) begin
            fall_data <= result_data;
        end
    end
endmodule
`default_nettype wire

// [verification/adc_result_capture_range_flag_bench.sv]
// Self-checking bench for the result capture core with a host latch model.
// Assumes the core and host latch files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module adc_result_capture_range_flag_bench;
    logic               core_clk;
    logic               rst;
    logic               start;
    logic signed [13:0] sample;
    logic        [11:0] data;
    logic        [11:0] cap_data;
    logic        [11:0] fall_data;
    logic        [1:0]  cap_range;
    logic               msb_n;
    logic               flag;
    logic               strobe;
    logic               cap_flag;
    logic        [31:0] seed;
    int                 bad_count;
    int                 samples_checked;
    int                 cyc;
    int                 tbl[9] = '{-8192, -2, -1, 0, 1, 2, 8190, 8191, -3};
    arcrf_core uut (.core_clk(core_clk), .rst(rst), .conversion_start_pulse(start),
        .analog_sample(sample), .result_data(data), .result_msb_n(msb_n),
        .range_exceeded_flag(flag), .result_valid_strobe(strobe));
    arcrf_host_latch host (.core_clk(core_clk), .result_data(data), .range_exceeded_flag(flag),
        .result_valid_strobe(strobe), .cap_data(cap_data), .cap_flag(cap_flag),
        .cap_range(cap_range), .fall_data(fall_data));
    // ====================
    // Helpers
    function automatic logic [31:0] xorshift(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk_word(input logic [11:0] g, input logic [11:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t word %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t bit %b expected %b", $time, g, e);
        end
    endtask
    // One full conversion; the expected code rounds half-LSB counts to the nearest centre.
    task automatic conv(input int s);
        logic        ef;
        logic [11:0] ec;
        logic        pf;
        int          n;
        ef = (s <= -1) || (s >= 8191);
        ec = (s < 0) ? 12'h0000 : (s > 8190) ? 12'hFFF : 12'((s + 1) / 2);
        pf = flag;
        n = 0;
        @(posedge core_clk) begin start <= 1'b1; sample <= 14'(s); end
        @(posedge core_clk) start <= 1'b0;
        while (n < 40) begin
            @(posedge core_clk) #1 n++;
            if (strobe === 1'b1) break;
            if (n < 12) chk_bit(flag, pf);
            if (n == 12) chk_word(data, ec);
        end
        chk_word(12'(n), 12'd13);
        chk_word(data, ec);
        chk_bit(flag, ef);
        chk_bit(msb_n, ~ec[11]);
        @(posedge core_clk) #1 chk_bit(strobe, 1'b1);
        chk_word(cap_data, ec);
        chk_word({10'h000, cap_range}, {10'h000, ef, ef & ec[11]});
        @(posedge core_clk) #1 chk_bit(strobe, 1'b0);
        @(posedge core_clk) #1 chk_word(fall_data, ec);
    endtask
    // ====================
    // Clock, watchdog and sequence
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 5000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        rst = 1'b1;
        start = 1'b0;
        sample = 14'h0000;
        seed = 32'h9c90_c6b5;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk) #1 chk_word(data, 12'h0000);
        chk_bit(flag, 1'b0);
        chk_bit(msb_n, 1'b1);
        foreach (tbl[i]) conv(tbl[i]);
        $display("boundary test done");
        repeat (40) begin
            seed = xorshift(seed);
            conv(int'(seed[12:0]) - 256);
        end
        $display("random test done");
        results();
    end
endmodule
`default_nettype wire
